/* rtl/mbs_coil_bank.sv */
`timescale 1ns/1ps
module mbs_coil_bank
  import mbs_pkg::*;
#(
  parameter int BITS = 512
)
(
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic wr_en,
  input wire logic [16:0] wr_base,
  input wire logic [7:0] wr_byte,
  input wire logic [7:0] wr_mask,
  output logic [BITS-1:0] coils
);
  logic [BITS-1:0] next_coils;

  // Byte lsb lands on the lowest coil of the group
  always_comb
  begin
    next_coils = coils;
    if (wr_en)
    begin
      for (int i = 0; i < 8; i++)
      begin
        if (wr_mask[i] && (32'(wr_base) + i < BITS))
          next_coils[32'(wr_base) + i] = wr_byte[i];
      end
    end
  end

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      coils <= '0;
    else
      coils <= next_coils;
  end
endmodule

/* rtl/mbs_map.svh */
`ifndef MBS_MAP_SVH
`define MBS_MAP_SVH
// Function codes served
`define MBS_FC_EVT 8'h0b
`define MBS_FC_COILS 8'h0f
`define MBS_FC_WREGS 8'h10
`define MBS_FC_MASK 8'h16
`define MBS_FC_RW 8'h17
// Exception reply fields and the event status word
`define MBS_EXC_FLAG 8'h80
`define MBS_EXC_FUNC 8'h01
`define MBS_EXC_ADDR 8'h02
`define MBS_STATUS_WORD 16'h0000
// Count limits
`define MBS_COIL_MAX 17'h00100
`define MBS_RD_MAX 17'h0007d
`define MBS_WR_MAX 17'h00064
// Byte positions within a frame
`define MBS_POS_FC 16'h0007
`define MBS_POS_BC_SHORT 16'h000c
`define MBS_POS_BC_RW 16'h0010
`define MBS_DATA_SHORT 16'h000d
`define MBS_DATA_RW 16'h0011
`define MBS_POS_MASK_END 16'h000d
// Reply lengths in bytes, whole frame; MBAP is the 6 leading bytes the length field leaves out
`define MBS_LEN_EXC 9'h009
`define MBS_LEN_ECHO 9'h00c
`define MBS_LEN_MASK 9'h00e
`define MBS_LEN_RW_HDR 9'h009
`define MBS_LEN_MBAP 9'h006
`endif

/* rtl/mbs_pkg.sv */
package mbs_pkg;
  typedef enum logic [1:0] {ST_RX, ST_EXEC, ST_TX} mbs_state_t;
  // One byte of a frame stream
  typedef struct packed {
    logic [7:0] data;
    logic last;
  } mbs_byte_t;
  // Fields captured from a request
  typedef struct packed {
    logic [15:0] tid;
    logic [15:0] pid;
    logic [7:0] unit;
    logic [7:0] fc;
    logic [15:0] f1;
    logic [15:0] f2;
    logic [15:0] f3;
    logic [15:0] f4;
    logic [7:0] bc;
  } mbs_req_t;
endpackage

/* rtl/mbs_reg_bank.sv */
`timescale 1ns/1ps
module mbs_reg_bank
  import mbs_pkg::*;
#(
  parameter int WORDS = 1024,
  parameter int AW = $clog2(WORDS)
)
(
  input wire logic sys_clk,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [15:0] wr_data,
  input wire logic [AW-1:0] rd_addr,
  output logic [15:0] rd_data
);
  // Plain storage, no reset, so it maps onto a RAM
  logic [15:0] mem [WORDS];

  // Read is combinational so a mask write can finish in one cycle
  assign rd_data = mem[rd_addr];

  always_ff @(posedge sys_clk)
  begin
    if (wr_en)
      mem[wr_addr] <= wr_data;
  end
endmodule

/* rtl/mbs_server.sv */
`timescale 1ns/1ps
`include "mbs_map.svh"
module mbs_server
  import mbs_pkg::*;
#(
  parameter int REG_WORDS = 1024,
  parameter int COIL_BITS = 512
)
(
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic rx_valid,
  input wire mbs_byte_t rx_byte,
  output logic rx_ready,
  output logic tx_valid,
  output mbs_byte_t tx_byte,
  input wire logic tx_ready,
  output logic [15:0] evt_count,
  output logic [COIL_BITS-1:0] coils
);
  localparam int AW = $clog2(REG_WORDS);
  localparam logic [16:0] REG_LIM = 17'(REG_WORDS);
  localparam logic [16:0] COIL_LIM = 17'(COIL_BITS);

  mbs_state_t state, next_state;
  mbs_req_t req, next_req;
  logic [15:0] pos, next_pos;
  logic wok, next_wok;
  logic err, next_err;
  logic [7:0] exc, next_exc;
  logic [7:0] hi, next_hi;
  logic [15:0] next_evt_count;
  logic [8:0] tidx, next_tidx;
  logic [8:0] tlen, next_tlen;
  logic next_rx_ready;
  logic next_tx_valid;
  mbs_byte_t next_tx_byte;

  logic reg_we;
  logic [AW-1:0] reg_waddr;
  logic [15:0] reg_wdata;
  logic [AW-1:0] reg_raddr;
  logic [15:0] reg_rdata;
  logic coil_we;
  logic [16:0] coil_base;
  logic [7:0] coil_mask;

  logic take;
  logic [7:0] d, fc_now;
  logic [15:0] dstart;
  logic [15:0] doff;
  logic [16:0] coil_end;
  logic [16:0] wbase;
  logic [8:0] ridx;
  logic [16:0] raddr;
  logic mask_bad;
  logic is_short;
  logic complete;

  mbs_reg_bank #(.WORDS(REG_WORDS), .AW(AW)) u_regs (
    .sys_clk(sys_clk),
    .wr_en(reg_we),
    .wr_addr(reg_waddr),
    .wr_data(reg_wdata),
    .rd_addr(reg_raddr),
    .rd_data(reg_rdata)
  );

  mbs_coil_bank #(.BITS(COIL_BITS)) u_coils (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .wr_en(coil_we),
    .wr_base(coil_base),
    .wr_byte(d),
    .wr_mask(coil_mask),
    .coils(coils)
  );

  // Field decode shared by the receive and reply logic
  always_comb
  begin
    take = (state == ST_RX) && rx_valid && rx_ready;
    d = rx_byte.data;
    // An inquiry ends on its own function byte, before req.fc holds it
    fc_now = (take && pos == `MBS_POS_FC) ? d : req.fc;
    is_short = (req.fc == `MBS_FC_COILS) || (req.fc == `MBS_FC_WREGS);
    dstart = (req.fc == `MBS_FC_RW) ? `MBS_DATA_RW : `MBS_DATA_SHORT;
    doff = pos - dstart;
    coil_end = {1'b0, req.f1} + {1'b0, req.f2};
    wbase = (req.fc == `MBS_FC_RW) ? {1'b0, req.f3} : {1'b0, req.f1};
    ridx = tidx - `MBS_LEN_RW_HDR;
    // Read group walks up one word per byte pair
    raddr = {1'b0, req.f1} + {9'h000, ridx[8:1]};
    mask_bad = {1'b0, req.f1} >= REG_LIM;
    case (fc_now)
      `MBS_FC_EVT: complete = 1'b1;
      `MBS_FC_MASK: complete = pos >= `MBS_POS_MASK_END;
      default: complete = (pos >= dstart) &&
                          ({1'b0, doff} + 17'h00001 >= {9'h000, req.bc});
    endcase
  end

  // Receive: capture fields, check counts, write data as it arrives
  always_comb
  begin
    next_state = state;
    next_req = req;
    next_pos = pos;
    next_wok = wok;
    next_err = err;
    next_exc = exc;
    next_hi = hi;
    next_evt_count = evt_count;
    next_tidx = tidx;
    next_tlen = tlen;
    reg_we = 1'b0;
    reg_waddr = wbase[AW-1:0] + AW'(doff[15:1]);
    reg_wdata = {hi, d};
    reg_raddr = (state == ST_TX) ? raddr[AW-1:0] : req.f1[AW-1:0];
    coil_we = 1'b0;
    coil_base = 17'({2'b00, req.f1} + {doff, 3'b000});
    coil_mask = 8'h00;
    for (int i = 0; i < 8; i++)
      coil_mask[i] = ({doff, 3'b000} + 19'(i)) < {2'b00, req.f2};
    case (state)
      ST_RX:
      begin
        if (take)
        begin
          next_pos = pos + 16'h0001;
          case (pos)
            16'h0000, 16'h0001: next_req.tid = {req.tid[7:0], d};
            16'h0002, 16'h0003: next_req.pid = {req.pid[7:0], d};
            16'h0006: next_req.unit = d;
            16'h0007: next_req.fc = d;
            16'h0008, 16'h0009: next_req.f1 = {req.f1[7:0], d};
            16'h000a, 16'h000b: next_req.f2 = {req.f2[7:0], d};
            16'h000c, 16'h000d: next_req.f3 = {req.f3[7:0], d};
            16'h000e, 16'h000f: next_req.f4 = {req.f4[7:0], d};
            default: ;
          endcase
          // Unknown function codes are refused at once
          if (pos == `MBS_POS_FC && d != `MBS_FC_EVT &&
              d != `MBS_FC_COILS && d != `MBS_FC_WREGS &&
              d != `MBS_FC_MASK && d != `MBS_FC_RW)
          begin
            next_err = 1'b1;
            next_exc = `MBS_EXC_FUNC;
          end
          // Counts are checked before any data byte is written
          if (pos == `MBS_POS_BC_SHORT && is_short)
          begin
            next_req.bc = d;
            if (req.fc == `MBS_FC_COILS)
              next_wok = (req.f2 != 16'h0000) &&
                         ({1'b0, req.f2} <= `MBS_COIL_MAX) &&
                         (coil_end <= COIL_LIM) &&
                         ({9'h000, d} == ((coil_end - {1'b0, req.f1}
                          + 17'h00007) >> 3));
            else
              next_wok = (req.f2 != 16'h0000) &&
                         (coil_end <= REG_LIM) &&
                         ({9'h000, d} == {req.f2, 1'b0});
          end
          if (pos == `MBS_POS_BC_RW && req.fc == `MBS_FC_RW)
          begin
            next_req.bc = d;
            next_wok = (req.f2 != 16'h0000) &&
                       ({1'b0, req.f2} <= `MBS_RD_MAX) &&
                       (req.f4 != 16'h0000) &&
                       ({1'b0, req.f4} <= `MBS_WR_MAX) &&
                       (coil_end <= REG_LIM) &&
                       ({1'b0, req.f3} + {1'b0, req.f4} <= REG_LIM) &&
                       ({9'h000, d} == {req.f4, 1'b0});
          end
          if ((pos == `MBS_POS_BC_SHORT && is_short) ||
              (pos == `MBS_POS_BC_RW && req.fc == `MBS_FC_RW))
          begin
            if (!next_wok && !err)
            begin
              next_err = 1'b1;
              next_exc = `MBS_EXC_ADDR;
            end
          end
          // Data bytes beyond the byte count are ignored
          if (wok && !err && pos >= dstart &&
              {1'b0, doff} < {9'h000, req.bc})
          begin
            if (req.fc == `MBS_FC_COILS)
              coil_we = 1'b1;
            else if (doff[0])
              reg_we = 1'b1;
            else
              next_hi = d;
          end
          if (rx_byte.last)
          begin
            if (pos < `MBS_POS_FC)
            begin
              // Too short to answer: dropped silently
              next_pos = 16'h0000;
              next_err = 1'b0;
              next_wok = 1'b0;
            end
            else
            begin
              next_state = ST_EXEC;
              if (!complete && !next_err)
              begin
                next_err = 1'b1;
                next_exc = `MBS_EXC_ADDR;
              end
            end
          end
        end
      end
      ST_EXEC:
      begin
        // Mask write is a read-modify-write in this one cycle
        if (!err && req.fc == `MBS_FC_MASK)
        begin
          if (mask_bad)
          begin
            next_err = 1'b1;
            next_exc = `MBS_EXC_ADDR;
          end
          else
          begin
            reg_we = 1'b1;
            reg_waddr = req.f1[AW-1:0];
            reg_wdata = (reg_rdata & req.f2) |
                        (req.f3 & ~req.f2);
          end
        end
        if (!err && !(req.fc == `MBS_FC_MASK && mask_bad) &&
            req.fc != `MBS_FC_EVT)
          next_evt_count = evt_count + 16'h0001;
        if (err || (req.fc == `MBS_FC_MASK && mask_bad))
          next_tlen = `MBS_LEN_EXC;
        else
          case (req.fc)
            `MBS_FC_MASK: next_tlen = `MBS_LEN_MASK;
            `MBS_FC_RW: next_tlen = `MBS_LEN_RW_HDR +
                                    {req.f2[7:0], 1'b0};
            default: next_tlen = `MBS_LEN_ECHO;
          endcase
        next_tidx = 9'h000;
        next_state = ST_TX;
      end
      ST_TX:
      begin
        if ((!tx_valid || tx_ready) && tidx < tlen)
          next_tidx = tidx + 9'h001;
        else if ((!tx_valid || tx_ready) && tidx == tlen)
        begin
          next_state = ST_RX;
          next_pos = 16'h0000;
          next_err = 1'b0;
          next_wok = 1'b0;
        end
      end
      default: next_state = ST_RX;
    endcase
  end

  // Reply byte for the current index; data reads follow the writes
  always_comb
  begin
    next_rx_ready = (next_state == ST_RX);
    next_tx_valid = tx_valid && !tx_ready;
    next_tx_byte = tx_byte;
    if (state == ST_TX && (!tx_valid || tx_ready) && tidx < tlen)
    begin
      next_tx_valid = 1'b1;
      next_tx_byte.last = (tidx == tlen - 9'h001);
      case (tidx)
        9'h000: next_tx_byte.data = req.tid[15:8];
        9'h001: next_tx_byte.data = req.tid[7:0];
        9'h002: next_tx_byte.data = req.pid[15:8];
        9'h003: next_tx_byte.data = req.pid[7:0];
        9'h004: next_tx_byte.data = 8'((tlen - `MBS_LEN_MBAP) >> 8);
        9'h005: next_tx_byte.data = 8'(tlen - `MBS_LEN_MBAP);
        9'h006: next_tx_byte.data = req.unit;
        9'h007: next_tx_byte.data = (tlen == `MBS_LEN_EXC &&
                                     req.fc != `MBS_FC_RW) || err ?
                                    (req.fc | `MBS_EXC_FLAG) : req.fc;
        default:
        begin
          if (err || tlen == `MBS_LEN_EXC && req.fc != `MBS_FC_RW)
            next_tx_byte.data = err ? exc : `MBS_EXC_ADDR;
          else if (req.fc == `MBS_FC_RW)
          begin
            if (tidx == 9'h008)
              next_tx_byte.data = {req.f2[6:0], 1'b0};
            else
              next_tx_byte.data = ridx[0] ? reg_rdata[7:0]
                                          : reg_rdata[15:8];
          end
          else if (req.fc == `MBS_FC_EVT)
            case (tidx)
              9'h008: next_tx_byte.data = 8'(`MBS_STATUS_WORD >> 8);
              9'h009: next_tx_byte.data = 8'(`MBS_STATUS_WORD);
              9'h00a: next_tx_byte.data = evt_count[15:8];
              default: next_tx_byte.data = evt_count[7:0];
            endcase
          else
            case (tidx)
              9'h008: next_tx_byte.data = req.f1[15:8];
              9'h009: next_tx_byte.data = req.f1[7:0];
              9'h00a: next_tx_byte.data = req.f2[15:8];
              9'h00b: next_tx_byte.data = req.f2[7:0];
              9'h00c: next_tx_byte.data = req.f3[15:8];
              default: next_tx_byte.data = req.f3[7:0];
            endcase
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state <= ST_RX;
      req <= '0;
      pos <= 16'h0000;
      wok <= 1'b0;
      err <= 1'b0;
      exc <= 8'h00;
      hi <= 8'h00;
      evt_count <= 16'h0000;
      tidx <= 9'h000;
      tlen <= 9'h000;
      rx_ready <= 1'b0;
      tx_valid <= 1'b0;
      tx_byte <= '0;
    end
    else
    begin
      state <= next_state;
      req <= next_req;
      pos <= next_pos;
      wok <= next_wok;
      err <= next_err;
      exc <= next_exc;
      hi <= next_hi;
      evt_count <= next_evt_count;
      tidx <= next_tidx;
      tlen <= next_tlen;
      rx_ready <= next_rx_ready;
      tx_valid <= next_tx_valid;
      tx_byte <= next_tx_byte;
    end
  end
endmodule

/* tb/mbs_master_model.sv */
`timescale 1ns/1ps
module mbs_master_model
  import mbs_pkg::*;
(
  input wire logic sys_clk,
  output logic rx_valid,
  output mbs_byte_t rx_byte,
  input wire logic rx_ready,
  input wire logic tx_valid,
  input wire mbs_byte_t tx_byte,
  output logic tx_ready
);
  initial
  begin
    rx_valid = 1'b0;
    rx_byte = '0;
    tx_ready = 1'b0;
  end

  // Each byte is held from a falling edge until a rising edge takes it
  task automatic send(input logic [7:0] q[$], output bit ok);
    int n;
    ok = 1'b1;
    foreach (q[i])
    begin
      @(negedge sys_clk);
      rx_valid = 1'b1;
      rx_byte = '{data: q[i], last: i == q.size() - 1};
      n = 0;
      while (!rx_ready && n < 200)
      begin
        @(negedge sys_clk);
        n++;
      end
      ok &= rx_ready;
      @(posedge sys_clk);
    end
    // Released line shows the inverse so stale bytes never look fresh
    @(negedge sys_clk);
    rx_valid = 1'b0;
    rx_byte = ~rx_byte;
  endtask

  // Ready is held low for stall cycles before each reply byte
  task automatic recv(output logic [7:0] r[$], input int stall,
    output bit ok);
    int n;
    int w;
    r = {};
    ok = 1'b0;
    w = 0;
    for (n = 0; n < 600 && !ok; n++)
    begin
      @(negedge sys_clk);
      tx_ready = w >= stall;
      if (tx_valid && tx_ready)
      begin
        r.push_back(tx_byte.data);
        ok = tx_byte.last;
        w = 0;
      end
      else if (tx_valid)
        w++;
    end
    @(negedge sys_clk);
    tx_ready = 1'b0;
  endtask
endmodule

/* tb/mbs_server_assertions.sv */
`timescale 1ns/1ps
module mbs_server_assertions
  import mbs_pkg::*;
#(
  parameter int COIL_BITS = 512
)
(
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic rx_valid,
  input wire mbs_byte_t rx_byte,
  input wire logic rx_ready,
  input wire logic tx_valid,
  input wire mbs_byte_t tx_byte,
  input wire logic tx_ready,
  input wire logic [15:0] evt_count,
  input wire logic [COIL_BITS-1:0] coils
);
  logic took_last;
  logic gave_last;

  // Final byte of a request or of a reply changing hands
  assign took_last = rx_valid && rx_ready && rx_byte.last;
  assign gave_last = tx_valid && tx_ready && tx_byte.last;

  default clocking cb @(posedge sys_clk);
  endclocking

  a_reset_clear: assert property (!resetn |-> !rx_ready && !tx_valid
    && evt_count == 16'h0 && coils == '0)
    else $error("outputs not cleared in reset");
  a_reply_held: assert property (disable iff (!resetn)
    tx_valid && !tx_ready |=> tx_valid && $stable(tx_byte))
    else $error("reply byte changed before taken");
  a_reply_start: assert property (disable iff (!resetn)
    took_last |=> ##[1:2] (tx_valid && !rx_ready))
    else $error("no reply after request");
  a_ready_return: assert property (disable iff (!resetn)
    gave_last |-> ##[1:2] rx_ready)
    else $error("receiver not reopened after reply");
  a_reply_single: assert property (disable iff (!resetn)
    gave_last |=> !tx_valid [*2])
    else $error("extra reply byte after last");
  // Counter moves in single steps only
  a_count_step: assert property (disable iff (!resetn)
    $changed(evt_count) |-> evt_count == $past(evt_count) + 16'h1)
    else $error("counter jumped");
  // Past term skips the edge after the receiver closes
  a_count_rx_quiet: assert property (disable iff (!resetn)
    rx_ready && !took_last && !$past(took_last) |=> $stable(evt_count))
    else $error("counter moved while receiving");
  a_count_tx_quiet: assert property (disable iff (!resetn)
    tx_valid |=> $stable(evt_count))
    else $error("counter moved while replying");
  a_coils_tx_quiet: assert property (disable iff (!resetn)
    tx_valid |=> $stable(coils))
    else $error("coils moved while replying");

  c_request: cover property (disable iff (!resetn) took_last);
  c_reply: cover property (disable iff (!resetn) gave_last);
  c_coils: cover property (disable iff (!resetn) $changed(coils));
endmodule

bind mbs_server mbs_server_assertions #(.COIL_BITS(COIL_BITS)) chk (
  .sys_clk(sys_clk), .resetn(resetn), .rx_valid(rx_valid),
  .rx_byte(rx_byte), .rx_ready(rx_ready), .tx_valid(tx_valid),
  .tx_byte(tx_byte), .tx_ready(tx_ready), .evt_count(evt_count),
  .coils(coils));

/* tb/tb_mbs_server.sv */
`timescale 1ns/1ps
module tb_mbs_server;
  import mbs_pkg::*;

  typedef struct {
    logic [7:0] fc;
    logic [15:0] a, b, c, d;
    logic [7:0] code;
  } mbs_row_t;

  logic sys_clk = 1'b0;
  logic resetn, rx_valid, rx_ready, tx_valid, tx_ready;
  mbs_byte_t rx_byte, tx_byte;
  logic [15:0] evt_count, cnt, n_ok;
  logic [511:0] coils;
  logic [7:0] q[$], r[$], e[$];
  logic [7:0] b8;
  int n_errors = 0;
  int checks_done = 0;
  int sz;
  bit ok, ex;
  mbs_row_t w;

  // Function, fields, expected exception code (zero for a normal reply)
  mbs_row_t rows[13] = '{
    '{8'h0f, 16'h0, 16'h100, 16'h0, 16'h0, 8'h0},
    '{8'h0f, 16'h0, 16'h101, 16'h0, 16'h0, 8'h2},
    '{8'h0f, 16'h1f8, 16'h9, 16'h0, 16'h0, 8'h2},
    '{8'h10, 16'h0, 16'h2, 16'h0, 16'h0, 8'h0},
    '{8'h10, 16'h3ff, 16'h2, 16'h0, 16'h0, 8'h2},
    '{8'h16, 16'h3ff, 16'hff, 16'h0, 16'h0, 8'h0},
    '{8'h16, 16'h400, 16'hff, 16'h0, 16'h0, 8'h2},
    '{8'h17, 16'h0, 16'h7d, 16'hc8, 16'h1, 8'h0},
    '{8'h17, 16'h0, 16'h7e, 16'hc8, 16'h1, 8'h2},
    '{8'h17, 16'hc8, 16'h1, 16'h0, 16'h64, 8'h0},
    '{8'h17, 16'hc8, 16'h1, 16'h0, 16'h65, 8'h2},
    '{8'h17, 16'h0, 16'h0, 16'hc8, 16'h1, 8'h2},
    '{8'h03, 16'h0, 16'h0, 16'h0, 16'h0, 8'h1}
  };

  mbs_server DUT (.sys_clk(sys_clk), .resetn(resetn), .rx_valid(rx_valid),
    .rx_byte(rx_byte), .rx_ready(rx_ready), .tx_valid(tx_valid),
    .tx_byte(tx_byte), .tx_ready(tx_ready), .evt_count(evt_count),
    .coils(coils));
  mbs_master_model mst (.sys_clk(sys_clk), .rx_valid(rx_valid),
    .rx_byte(rx_byte), .rx_ready(rx_ready), .tx_valid(tx_valid),
    .tx_byte(tx_byte), .tx_ready(tx_ready));

  always #2.5 sys_clk = ~sys_clk;

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic check(input bit c, input string m);
    checks_done++;
    if (!c)
    begin
      n_errors++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask

  task automatic w16(ref logic [7:0] x[$], input logic [15:0] v);
    x.push_back(v[15:8]);
    x.push_back(v[7:0]);
  endtask

  // Frame head with a fixed transaction id, then two words
  task automatic pf(ref logic [7:0] x[$], input logic [15:0] n,
    input logic [7:0] fc, input logic [15:0] a, b);
    x = {8'h12, 8'h34, 8'h00, 8'h00, n[15:8], n[7:0], 8'h01, fc};
    w16(x, a);
    w16(x, b);
  endtask

  // A missing reply ends the run at once; a request not taken is only counted as a mismatch
  task automatic xact(input int stall);
    mst.send(q, ok);
    check(ok, "request not taken");
    mst.recv(r, stall, ok);
    check(ok, "no reply");
    if (!ok)
      report_and_stop();
  endtask

  task automatic cmp(input string m);
    bit same;
    same = r.size() == e.size();
    foreach (e[i])
      same &= i < r.size() && r[i] === e[i];
    check(same, m);
  endtask

  task automatic build(input mbs_row_t t);
    int nb;
    nb = t.fc == 8'h0f ? (t.b + 7) / 8 : t.fc == 8'h10 ? 2 * t.b : 2 * t.d;
    pf(q, 16'h0, t.fc, t.a, t.b);
    if (t.fc == 8'h16 || t.fc == 8'h17)
      w16(q, t.c);
    if (t.fc == 8'h17)
      w16(q, t.d);
    if (t.fc == 8'h0f || t.fc == 8'h10 || t.fc == 8'h17)
    begin
      q.push_back(8'(nb));
      repeat (nb)
        q.push_back(8'h5a);
    end
  endtask

  task automatic evt_check(input logic [15:0] v);
    pf(q, 16'h0, 8'h0b, 16'h0, 16'h0);
    q = q[0:7];
    xact(1);
    pf(e, 16'h6, 8'h0b, 16'h0, v);
    cmp("event counter reply");
  endtask

  task automatic coil_wr(input logic [15:0] a, b, input logic [7:0] d0, d1);
    pf(q, 16'h0, 8'h0f, a, b);
    q = {q, 8'h2, d0, d1};
    xact(2);
    pf(e, 16'h6, 8'h0f, a, b);
    cmp("coil echo");
  endtask

  // Combined request writing one word and reading rn words
  task automatic rw(input logic [15:0] ra, rn, wa, wv);
    pf(q, 16'h0, 8'h17, ra, rn);
    w16(q, wa);
    w16(q, 16'h1);
    q.push_back(8'h2);
    w16(q, wv);
    xact(0);
    pf(e, 16'(3 + 2 * rn), 8'h17, 16'h0, 16'h0);
    e = {e[0:7], 8'(2 * rn)};
  endtask

  task automatic do_reset();
    resetn = 1'b0;
    repeat (2) @(negedge sys_clk);
    resetn = 1'b1;
    check(evt_count === 16'h0 && coils === '0, "reset values");
  endtask

  initial
  begin
    resetn = 1'b1;
    n_ok = 16'h0;
    #1;
    do_reset();
    evt_check(16'h0);
    $display("done: reset and first inquiry");
    foreach (rows[k])
    begin
      w = rows[k];
      ex = w.code != 8'h0;
      cnt = evt_count;
      build(w);
      xact(k % 3);
      n_ok += {15'h0, !ex};
      sz = ex ? 9 : w.fc == 8'h17 ? 9 + 2 * w.b : w.fc == 8'h16 ? 14 : 12;
      b8 = ex ? w.code : w.fc == 8'h17 ? 8'(2 * w.b) : w.a[15:8];
      check(r.size() == sz, "reply length");
      check(r[7] === (ex ? w.fc | 8'h80 : w.fc), "function byte");
      check(r[8] === b8, "code or count byte");
      check(evt_count === cnt + {15'h0, !ex}, "counter step");
    end
    $display("done: table of requests");
    evt_check(n_ok);
    evt_check(n_ok);
    $display("done: counter inquiries");
    coil_wr(16'h0, 16'h10, 8'ha5, 8'hf0);
    check(coils[15:0] === 16'hf0a5, "coil map");
    coil_wr(16'h3, 16'ha, 8'hff, 8'h00);
    check(coils[15:0] === ((16'hf0a5 & ~16'h1ff8) | 16'h07f8), "coil span");
    $display("done: coils");
    pf(q, 16'h0, 8'h10, 16'h5, 16'h2);
    q.push_back(8'h4);
    w16(q, 16'h1234);
    w16(q, 16'h2345);
    xact(1);
    pf(e, 16'h6, 8'h10, 16'h5, 16'h2);
    cmp("word write echo");
    rw(16'h5, 16'h2, 16'h8, 16'hbeef);
    w16(e, 16'h1234);
    w16(e, 16'h2345);
    cmp("read back");
    pf(q, 16'h0, 8'h16, 16'h5, 16'hf0f0);
    w16(q, 16'h0a0a);
    xact(0);
    pf(e, 16'h8, 8'h16, 16'h5, 16'hf0f0);
    w16(e, 16'h0a0a);
    cmp("mask echo");
    rw(16'h8, 16'h1, 16'h9, 16'h0);
    w16(e, 16'hbeef);
    cmp("written word");
    rw(16'h5, 16'h1, 16'h9, 16'h0);
    w16(e, (16'h1234 & 16'hf0f0) | (16'h0a0a & ~16'hf0f0));
    cmp("mask result");
    // Frame cut inside its data: exception, and the counter stands still
    pf(q, 16'h0, 8'h10, 16'h5, 16'h2);
    q = {q, 8'h4, 8'h11, 8'h11};
    xact(2);
    pf(e, 16'h3, 8'h90, 16'h0, 16'h0);
    e = {e[0:7], 8'h02};
    cmp("truncated frame");
    evt_check(n_ok + 16'h7);
    $display("done: registers");
    do_reset();
    $display("done: second reset");
    report_and_stop();
  end
endmodule
